// >>> hdl/lci_consts.svh
`ifndef LCI_CONSTS_SVH
`define LCI_CONSTS_SVH
// Channel count and address layout
`define LCI_NUM_CH          14
`define LCI_CH_STRIDE       8'h10
`define LCI_OFS_CODE        4'h3
`define LCI_OFS_IRQEN       4'h4
`define LCI_OFS_GLOBAL_IRQ  8'hE0
`define LCI_OFS_GLOBAL_LCV  8'hE5
// Coding register fields
`define LCI_BIT_CODE_SEL    5
`define LCI_BIT_RES_HI      4
`define LCI_BIT_RES_LO      3
`define LCI_BIT_INS_BPV     2
`define LCI_BIT_INS_BER     1
// Enable register fields
`define LCI_BIT_DRV_EN      6
`define LCI_BIT_FIFO_EN     5
`define LCI_BIT_LCV_EN      4
`define LCI_BIT_AIS_EN      2
`define LCI_BIT_LOS_EN      1
`define LCI_BIT_PAT_EN      0
// Global register bits
`define LCI_BIT_GIE         0
`define LCI_BIT_LCV_OVF_SEL 7
// Reset values
`define LCI_RST_REG         8'h00
`endif

// >>> hdl/lci_pkg.sv
package lci_pkg;
  // Line code chosen in single-rail mode
  typedef enum logic {LCI_CODE_ZS = 1'b0, LCI_CODE_AMI = 1'b1} lci_code_t;
  // Receive resistor choice
  typedef enum logic [1:0] {LCI_RES_NONE = 2'b00, LCI_RES_240 = 2'b01,
                            LCI_RES_210 = 2'b10, LCI_RES_150 = 2'b11} lci_res_t;
  // Microprocessor port request
  typedef struct packed {
    logic       cs;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lci_bus_t;
  // Per-channel alarm status levels
  typedef struct packed {
    logic driverFail;
    logic fifoLimit;
    logic codeViolation;
    logic counterOverflow;
    logic allOnes;
    logic signalLoss;
    logic patternDetect;
  } lci_alarm_t;
endpackage

// >>> hdl/lci_insert_edge.sv
`timescale 1ns/1ps
// Rising-edge detector for an insert trigger, sampled on the transmit clock
module lci_insert_edge (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rstn,
  // Transmit clock sampled as a synchronous input
  input  wire logic txLineClock,
  // Register bit and one-shot request
  input  wire logic trigger,
  output logic      insertPulse
);
  logic clkPrev, next_clkPrev;
  logic trigPrev, next_trigPrev;
  logic next_insertPulse;
  logic txRise;

  ////////////////////////////////////////////////////////////////////////////////
  // Sample only at transmit clock rising edges
  always_comb begin
    txRise           = txLineClock & ~clkPrev;
    next_clkPrev     = txLineClock;
    next_trigPrev    = trigPrev;
    next_insertPulse = 1'b0;
    if (txRise) begin
      next_trigPrev    = trigger;
      next_insertPulse = trigger & ~trigPrev;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      clkPrev     <= 1'b0;
      trigPrev    <= 1'b0;
      insertPulse <= 1'b0;
    end else begin
      clkPrev     <= next_clkPrev;
      trigPrev    <= next_trigPrev;
      insertPulse <= next_insertPulse;
    end
  end
endmodule

// >>> hdl/lci_channel_regs.sv
`timescale 1ns/1ps
`include "lci_consts.svh"
// Address map
//   addr[7:4] picks the channel, 0 to 13
//   addr[3:0] 3 is the coding register
//   addr[3:0] 4 is the interrupt enable register
//   Channels 14 and 15 are not decoded
//   Other low nibbles are not decoded either
//   Unmapped writes are dropped
//   Unmapped reads return zero
//
// Bus timing
//   One request per cs-high cycle
//   Writes land at the edge that takes them
//   Read data follows one cycle later
//   Read data holds until the next read
//   Back-to-back requests are fine
//
// Coding register layout
//   Bits 7:6 and 0 spare but stored
//   Bit 5 line code, bits 4:3 resistor
//   Bit 2 violation insert, bit 1 error insert
//
// Enable register layout
//   Bits 7 and 3 spare but stored
//   Bits 6, 5, 4, 2, 1, 0 gate one source each
//
// Insert triggers
//   Transmit clocks are sampled as plain inputs
//   They must run below half the core clock
//   A trigger counts only at a transmit rise
//   A 0 then 1 between two rises is missed
//   Each pulse lasts one core cycle
//
// Interrupt path
//   Status follows the alarm levels, not sticky
//   Status never depends on the enables
//   Request is one cycle behind alarm inputs
//   Global registers live outside this block
//
// Reset
//   Synchronous, all registers clear to zero
//   Outputs clear on the same edge
//
module lci_channel_regs (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rstn,
  // Microprocessor port
  input  wire lci_pkg::lci_bus_t     busReq,
  output logic [7:0]                 busRdata,
  // Global register bits held elsewhere
  input  wire logic [7:0]            globalIrqReg,
  input  wire logic [7:0]            globalLcvReg,
  // Per-channel transmit clocks and alarm levels
  input  wire logic [13:0]           txLineClock,
  input  wire lci_pkg::lci_alarm_t [13:0] alarmIn,
  // Per-channel controls to the datapath
  output lci_pkg::lci_code_t [13:0]  lineCodeSelect,
  output lci_pkg::lci_res_t  [13:0]  rxResistorSelect,
  output logic [13:0]                violationInsert,
  output logic [13:0]                bitErrorInsert,
  // Latest status snapshot and interrupt
  output logic [13:0][7:0]           alarmStatus,
  output logic                       irqReq
);
  import lci_pkg::*;

  logic [7:0] codeReg  [`LCI_NUM_CH];
  logic [7:0] irqEnReg [`LCI_NUM_CH];
  logic [7:0] next_codeReg  [`LCI_NUM_CH];
  logic [7:0] next_irqEnReg [`LCI_NUM_CH];
  logic [7:0] next_busRdata;
  logic [13:0][7:0] next_alarmStatus;
  logic [13:0] chanIrq;
  logic next_irqReq;
  lci_code_t [13:0] next_lineCodeSelect;
  lci_res_t  [13:0] next_rxResistorSelect;

  // Channel index when the address hits a channel, else 4'hF
  function automatic logic [3:0] chanOf(input logic [7:0] a);
    chanOf = (a[7:4] < 4'(`LCI_NUM_CH)) ? a[7:4] : 4'hF;
  endfunction

  // Status byte for one channel from live alarm levels
  function automatic logic [7:0] statusOf(input lci_alarm_t al, input logic ovfSel);
    statusOf = 8'h00;
    statusOf[`LCI_BIT_DRV_EN]  = al.driverFail;
    statusOf[`LCI_BIT_FIFO_EN] = al.fifoLimit;
    statusOf[`LCI_BIT_LCV_EN]  = ovfSel ? al.counterOverflow : al.codeViolation;
    statusOf[`LCI_BIT_AIS_EN]  = al.allOnes;
    statusOf[`LCI_BIT_LOS_EN]  = al.signalLoss;
    statusOf[`LCI_BIT_PAT_EN]  = al.patternDetect;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes and read mux
  always_comb begin
    logic [3:0] ch;
    ch = chanOf(busReq.addr);
    next_busRdata = busRdata;
    for (int i = 0; i < `LCI_NUM_CH; i++) begin
      next_codeReg[i]  = codeReg[i];
      next_irqEnReg[i] = irqEnReg[i];
    end
    if (busReq.cs && ch != 4'hF) begin
      if (busReq.wr) begin
        if (busReq.addr[3:0] == `LCI_OFS_CODE)
          next_codeReg[ch] = busReq.wdata;
        else if (busReq.addr[3:0] == `LCI_OFS_IRQEN)
          next_irqEnReg[ch] = busReq.wdata;
      end else begin
        if (busReq.addr[3:0] == `LCI_OFS_CODE)
          next_busRdata = codeReg[ch];
        else if (busReq.addr[3:0] == `LCI_OFS_IRQEN)
          next_busRdata = irqEnReg[ch];
        else
          next_busRdata = 8'h00;
      end
    end else if (busReq.cs && !busReq.wr) begin
      next_busRdata = 8'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < `LCI_NUM_CH; i++) begin
        codeReg[i]  <= `LCI_RST_REG;
        irqEnReg[i] <= `LCI_RST_REG;
      end
      busRdata <= 8'h00;
    end else begin
      for (int i = 0; i < `LCI_NUM_CH; i++) begin
        codeReg[i]  <= next_codeReg[i];
        irqEnReg[i] <= next_irqEnReg[i];
      end
      busRdata <= next_busRdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status snapshot and interrupt request
  always_comb begin
    for (int i = 0; i < `LCI_NUM_CH; i++) begin
      next_alarmStatus[i] = statusOf(alarmIn[i], globalLcvReg[`LCI_BIT_LCV_OVF_SEL]);
      chanIrq[i] = |(next_alarmStatus[i] & irqEnReg[i]);
    end
    next_irqReq = globalIrqReg[`LCI_BIT_GIE] & (|chanIrq);
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      alarmStatus <= '0;
      irqReq      <= 1'b0;
    end else begin
      alarmStatus <= next_alarmStatus;
      irqReq      <= next_irqReq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Field values decoded from the coding registers
  always_comb begin
    for (int i = 0; i < `LCI_NUM_CH; i++) begin
      next_lineCodeSelect[i]   = lci_code_t'(codeReg[i][`LCI_BIT_CODE_SEL]);
      next_rxResistorSelect[i] = lci_res_t'(codeReg[i][`LCI_BIT_RES_HI:`LCI_BIT_RES_LO]);
    end
  end

  // Field outputs registered straight from flops
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < `LCI_NUM_CH; i++) begin
        lineCodeSelect[i]   <= LCI_CODE_ZS;
        rxResistorSelect[i] <= LCI_RES_NONE;
      end
    end else begin
      for (int i = 0; i < `LCI_NUM_CH; i++) begin
        lineCodeSelect[i]   <= next_lineCodeSelect[i];
        rxResistorSelect[i] <= next_rxResistorSelect[i];
      end
    end
  end

  // Insert edge detectors, two per channel

  for (genvar g = 0; g < `LCI_NUM_CH; g++) begin : gEdge
    lci_insert_edge uBpv (
      .core_clk    (core_clk),
      .rstn        (rstn),
      .txLineClock (txLineClock[g]),
      .trigger     (codeReg[g][`LCI_BIT_INS_BPV]),
      .insertPulse (violationInsert[g])
    );
    lci_insert_edge uBer (
      .core_clk    (core_clk),
      .rstn        (rstn),
      .txLineClock (txLineClock[g]),
      .trigger     (codeReg[g][`LCI_BIT_INS_BER]),
      .insertPulse (bitErrorInsert[g])
    );
  end
endmodule

// >>> testbench/lci_channel_regs_asserts.sv
`timescale 1ns/1ps
// Port checks for the register bank
module lci_channel_regs_asserts (
  // Clock and reset
  input wire logic                       core_clk,
  input wire logic                       rstn,
  // Watched ports
  input wire lci_pkg::lci_bus_t          busReq,
  input wire logic [7:0]                 busRdata,
  input wire logic [7:0]                 globalIrqReg,
  input wire lci_pkg::lci_alarm_t [13:0] alarmIn,
  input wire lci_pkg::lci_code_t [13:0]  lineCodeSelect,
  input wire lci_pkg::lci_res_t [13:0]   rxResistorSelect,
  input wire logic [13:0]                violationInsert,
  input wire logic [13:0]                bitErrorInsert,
  input wire logic [13:0][7:0]           alarmStatus,
  input wire logic                       irqReq
);
  import lci_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Bus request shapes
  sequence codeWr;
    busReq.cs && busReq.wr && busReq.addr == 8'h03;
  endsequence
  sequence holeRd;
    busReq.cs && !busReq.wr && busReq.addr[3:0] == 4'h5;
  endsequence
  // Register, interrupt and pulse checks
  code_sel_a: assert property (codeWr |-> ##2 lineCodeSelect[0] == $past(busReq.wdata[5], 2))
    else $error("code select wrong");
  res_sel_a: assert property (codeWr |-> ##2 rxResistorSelect[0] == $past(busReq.wdata[4:3], 2))
    else $error("resistor select wrong");
  hole_read_a: assert property (holeRd |=> busRdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!(busReq.cs && !busReq.wr) |=> $stable(busRdata))
    else $error("read data moved");
  irq_global_a: assert property (!globalIrqReg[0] |=> !irqReq)
    else $error("irq without global enable");
  irq_cause_a: assert property (irqReq |-> $past(|alarmIn))
    else $error("irq without alarm");
  status_live_a: assert property (1 |=> alarmStatus[3][1] == $past(alarmIn[3].signalLoss))
    else $error("status not live");
  pulse_once_a: assert property (violationInsert[0] || bitErrorInsert[0] |=> !violationInsert[0] && !bitErrorInsert[0])
    else $error("insert pulse too long");
endmodule
bind lci_channel_regs lci_channel_regs_asserts u_lci_channel_regs_asserts (.*);

// >>> testbench/tb_lci_channel_regs.sv
`timescale 1ns/1ps
// Self-checking bench for the register bank
module tb_lci_channel_regs;
  import lci_pkg::*;
  logic              core_clk = 1'b0;
  logic              rstn = 1'b0;
  lci_bus_t          busReq = '0;
  logic [7:0]        busRdata;
  logic [7:0]        globalIrqReg = 8'h00;
  logic [7:0]        globalLcvReg = 8'h00;
  logic [13:0]       txLineClock = '0;
  lci_alarm_t [13:0] alarmIn = '0;
  lci_code_t [13:0]  lineCodeSelect;
  lci_res_t [13:0]   rxResistorSelect;
  logic [13:0]       violationInsert;
  logic [13:0]       bitErrorInsert;
  logic [13:0][7:0]  alarmStatus;
  logic              irqReq;
  int                failures = 0;
  int                n_checks = 0;
  int                nViol = 0;
  int                nErr = 0;
  int                ens[6] = '{6, 5, 4, 2, 1, 0};
  always #2.5 core_clk = ~core_clk;
  // Count insert pulses on channel 0
  always @(posedge core_clk) begin
    nViol += violationInsert[0];
    nErr += bitErrorInsert[0];
  end
  lci_channel_regs u_lci_channel_regs (.core_clk(core_clk), .rstn(rstn), .busReq(busReq), .busRdata(busRdata),
    .globalIrqReg(globalIrqReg), .globalLcvReg(globalLcvReg), .txLineClock(txLineClock), .alarmIn(alarmIn),
    .lineCodeSelect(lineCodeSelect), .rxResistorSelect(rxResistorSelect), .violationInsert(violationInsert),
    .bitErrorInsert(bitErrorInsert), .alarmStatus(alarmStatus), .irqReq(irqReq));
  ////////////////////////////////////////////////////////////////
  // Compare one byte
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Bus access, one cycle per request
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    busReq <= '{1'b1, w, a, d};
    @(posedge core_clk);
    busReq.cs <= 1'b0;
    #1;
  endtask
  task automatic settle();
    repeat (3) @(posedge core_clk);
    #1;
  endtask
  // One slow transmit clock period
  task automatic txTick();
    @(posedge core_clk);
    txLineClock <= 14'h3FFF;
    repeat (4) @(posedge core_clk);
    txLineClock <= 14'h0000;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic report_and_stop();
    $display("Checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // Watchdog
  initial begin
    #50000;
    failures++;
    report_and_stop();
  end
  // Test sequence
  initial begin
    repeat (10) @(posedge core_clk);
    rstn <= 1'b1;
    for (int c = 0; c < 28; c++) begin
      acc(1'b0, {c[4:1], (c[0] ? 4'h4 : 4'h3)}, 8'hFF);
      chk("reset value", 8'h00, busRdata);
      acc(1'b1, {c[4:1], (c[0] ? 4'h4 : 4'h3)}, 8'hC9 ^ c[7:0]);
      acc(1'b0, {c[4:1], (c[0] ? 4'h4 : 4'h3)}, 8'h00);
      chk("readback", 8'hC9 ^ c[7:0], busRdata);
    end
    acc(1'b1, 8'hE3, 8'hFF);
    acc(1'b0, 8'hE3, 8'h00);
    chk("unmapped read", 8'h00, busRdata);
    acc(1'b0, 8'h15, 8'h00);
    chk("hole read", 8'h00, busRdata);
    $display("Address map test done");
    for (int v = 0; v < 8; v++) begin
      acc(1'b1, 8'h23, {2'b00, v[2:0], 3'b000});
      settle();
      chk("line code", {7'h00, v[2]}, lineCodeSelect[2]);
      chk("resistor", {6'h00, v[1:0]}, rxResistorSelect[2]);
    end
    $display("Code select test done");
    acc(1'b1, 8'h03, 8'h00);
    txTick();
    acc(1'b1, 8'h03, 8'h04);
    txTick();
    acc(1'b1, 8'h03, 8'h00);
    acc(1'b1, 8'h03, 8'h04);
    txTick();
    chk("violation pulses", 8'h01, nViol[7:0]);
    acc(1'b1, 8'h03, 8'h00);
    txTick();
    acc(1'b1, 8'h03, 8'h02);
    txTick();
    txTick();
    chk("error pulses", 8'h01, nErr[7:0]);
    $display("Insert test done");
    foreach (ens[i]) begin
      @(posedge core_clk);
      alarmIn[3] <= 7'(1 << ens[i]);
      globalIrqReg <= 8'h01;
      acc(1'b1, 8'h34, 8'h00);
      settle();
      chk("masked irq", 8'h00, {7'h00, irqReq});
      chk("status", 8'(1 << ens[i]), alarmStatus[3]);
      acc(1'b1, 8'h34, 8'(1 << ens[i]));
      settle();
      chk("enabled irq", 8'h01, {7'h00, irqReq});
      @(posedge core_clk);
      globalIrqReg <= 8'h00;
      settle();
      chk("global off irq", 8'h00, {7'h00, irqReq});
    end
    acc(1'b1, 8'h34, 8'h10);
    @(posedge core_clk);
    alarmIn[3] <= 7'h08;
    globalLcvReg <= 8'h80;
    globalIrqReg <= 8'h01;
    settle();
    chk("overflow status", 8'h10, alarmStatus[3]);
    chk("overflow irq", 8'h01, {7'h00, irqReq});
    $display("Interrupt test done");
    report_and_stop();
  end
endmodule
